// >>> design/pcsr_regs.v
`timescale 1ns/100ps
`include "pcsr_map.vh"
// Contract
// - all-zero command: only configuration accesses answered
// - bit 0 enables claiming I/O cycles
// - bit 1 enables claiming memory cycles
// - bit 2 required before mastering anything
// - bit 3 reads zero; special cycles ignored
// - bits 4,5,7 read zero, writes ignored
// - bit 9 zero; fast chaining same target only
// - reserved command and status bits read zero
// - bit 6 gates parity error reaction
// - bit 8 enables system error driver
// - status reads current, write one clears
// - status bit 7 always reads one
// - bit 8 set on mastered parity error
// - DEVSEL timing field always reads medium
// - signaled target abort always reads zero
// - bit 12 set on received target abort
// - bit 13 set on master abort, except special cycles
// - bit 14 set when driving system error
// - bit 15 set on any parity error
module pcsr_regs
(
	// clock and reset
	input wire mclk,
	input wire rst,
	// configuration access port
	input wire cfgRead,
	input wire cfgWrite,
	input wire [7:0] cfgAddr,
	input wire [3:0] cfgByteEn,
	input wire [31:0] cfgWrData,
	output wire cfgHit,
	output wire [31:0] cfgRdData,
	output wire cfgRdValid,
	// target decode
	input wire addrValid,
	input wire [1:0] addrSpace,
	input wire addrMatch,
	output wire targetClaim,
	output wire cfgClaim,
	// master request
	input wire masterReq,
	input wire masterBackToBack,
	input wire sameTarget,
	output wire masterGo,
	output wire fastB2bGo,
	// bus events
	input wire dataParityErr,
	input wire addrParityErr,
	input wire perrSeen,
	input wire masterActive,
	input wire targetAbortRcvd,
	input wire masterAbortRcvd,
	input wire specialCycleXfer,
	input wire systemErrReq,
	// parity error pin, open drain
	output wire perrOut,
	output wire perrOe,
	// system error pin, open drain
	output wire serrOut,
	output wire serrOe,
	// enables for the rest of the device
	output wire ioSpaceEn,
	output wire memSpaceEn,
	output wire busMasterEn,
	output wire parityRespEn,
	output wire serrEn
);

localparam STICKY_N = 5;

// sticky status bit positions, indexed by generate
function [3:0] stickyPos;
	input integer idx;
	begin
		case (idx)
			0: stickyPos = `PCSR_STS_DATAPAR;
			1: stickyPos = `PCSR_STS_RCV_TABORT;
			2: stickyPos = `PCSR_STS_RCV_MABORT;
			3: stickyPos = `PCSR_STS_SIG_SERR;
			4: stickyPos = `PCSR_STS_PARITY;
			default: stickyPos = `PCSR_STS_PARITY;
		endcase
	end
endfunction

// true when the access targets the command/status dword
function hitsCmd;
	input [7:0] addr;
	begin
		hitsCmd = ((addr & 8'hFC) == `PCSR_CMD_OFFSET);
	end
endfunction

reg [15:0] cmd_reg;
reg [15:0] cmd_next;
reg [31:0] rdData_reg;
reg [31:0] rdData_next;
reg rdValid_reg;
reg perrDrive_reg;
reg serrDrive_reg;
wire [15:0] statusWord;
wire [15:0] stsClear;
wire [STICKY_N-1:0] stickySet;
wire [STICKY_N-1:0] stickyFlag;
wire [15:0] stickyWord;
wire accessHit;
wire wrHit;
wire dataParSet;
wire serrCause;
wire perrCause;

assign accessHit = hitsCmd(cfgAddr);
assign wrHit = cfgWrite & accessHit;

// command register
always @*
begin
	cmd_next = cmd_reg;
	if (wrHit)
	begin
		if (cfgByteEn[0])
			cmd_next[7:0] = cfgWrData[7:0];
		if (cfgByteEn[1])
			cmd_next[15:8] = cfgWrData[15:8];
	end
	cmd_next = cmd_next & `PCSR_CMD_RW_MASK;
end

always @(posedge mclk or posedge rst)
begin
	if (rst)
		cmd_reg <= `PCSR_CMD_RESET;
	else
		cmd_reg <= cmd_next;
end

assign ioSpaceEn = cmd_reg[`PCSR_CMD_IO];
assign memSpaceEn = cmd_reg[`PCSR_CMD_MEM];
assign busMasterEn = cmd_reg[`PCSR_CMD_MASTER];
assign parityRespEn = cmd_reg[`PCSR_CMD_PARITY];
assign serrEn = cmd_reg[`PCSR_CMD_SERR];

// status clear mask, upper half of the dword
assign stsClear[7:0] = (wrHit & cfgByteEn[2]) ? cfgWrData[23:16] : 8'h00;
assign stsClear[15:8] = (wrHit & cfgByteEn[3]) ? cfgWrData[31:24] : 8'h00;

// event causes
// own parity pin counts as well as one seen on the bus
assign dataParSet = (perrSeen | perrDrive_reg) & masterActive & parityRespEn;
assign perrCause = dataParityErr & parityRespEn;
assign serrCause = serrEn & ((addrParityErr & parityRespEn) | systemErrReq);

assign stickySet[0] = dataParSet;
assign stickySet[1] = targetAbortRcvd & masterActive;
assign stickySet[2] = masterAbortRcvd & masterActive & ~specialCycleXfer;
assign stickySet[3] = serrDrive_reg;
assign stickySet[4] = dataParityErr | addrParityErr;

genvar gi;
generate
	for (gi = 0; gi < STICKY_N; gi = gi + 1)
	begin : gStatus
		pcsr_sticky_bit uSticky
		(
			.mclk(mclk),
			.rst(rst),
			.setEvt(stickySet[gi]),
			.clrReq(stsClear[stickyPos(gi)]),
			.flag(stickyFlag[gi])
		);
		assign stickyWord[stickyPos(gi)] = stickyFlag[gi];
	end
endgenerate

// bits not held by sticky cells
assign stickyWord[6:0] = 7'h00;
assign stickyWord[`PCSR_STS_FASTB2B] = 1'b0;
assign stickyWord[`PCSR_STS_DEVSEL_HI:`PCSR_STS_DEVSEL_LO] = 2'h0;
assign stickyWord[`PCSR_STS_SIG_TABORT] = 1'b0;

assign statusWord = stickyWord | `PCSR_STS_FIXED;

// pin drivers: registered, asserted the cycle after each cycle a cause is present
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		perrDrive_reg <= 1'b0;
		serrDrive_reg <= 1'b0;
	end
	else
	begin
		perrDrive_reg <= perrCause;
		serrDrive_reg <= serrCause;
	end
end

assign perrOut = 1'b0;
assign perrOe = perrDrive_reg;
assign serrOut = 1'b0;
assign serrOe = serrDrive_reg;

// read path
always @*
begin
	rdData_next = 32'h00000000;
	if (cfgRead & accessHit)
		rdData_next = {statusWord, cmd_reg};
end

always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		rdData_reg <= 32'h00000000;
		rdValid_reg <= 1'b0;
	end
	else
	begin
		rdData_reg <= rdData_next;
		rdValid_reg <= cfgRead;
	end
end

assign cfgRdData = rdData_reg;
assign cfgRdValid = rdValid_reg;
assign cfgHit = (cfgRead | cfgWrite) & accessHit;

pcsr_access_gate uGate
(
	.ioEn(ioSpaceEn),
	.memEn(memSpaceEn),
	.masterEn(busMasterEn),
	.addrValid(addrValid),
	.addrSpace(addrSpace),
	.addrMatch(addrMatch),
	.masterReq(masterReq),
	.masterBackToBack(masterBackToBack),
	.sameTarget(sameTarget),
	.targetClaim(targetClaim),
	.cfgClaim(cfgClaim),
	.masterGo(masterGo),
	.fastB2bGo(fastB2bGo)
);

endmodule // pcsr_regs

// >>> design/pcsr_map.vh
`ifndef PCSR_MAP_VH
`define PCSR_MAP_VH

// configuration dword holding command (low half) and status (high half)
`define PCSR_CMD_OFFSET 8'h04
`define PCSR_ADDR_W 8

// command bit positions
`define PCSR_CMD_IO 0
`define PCSR_CMD_MEM 1
`define PCSR_CMD_MASTER 2
`define PCSR_CMD_SPECIAL 3
`define PCSR_CMD_MWI 4
`define PCSR_CMD_PALETTE 5
`define PCSR_CMD_PARITY 6
`define PCSR_CMD_STEPPING 7
`define PCSR_CMD_SERR 8
`define PCSR_CMD_FASTB2B 9

// writable command bits and reset value
`define PCSR_CMD_RW_MASK 16'h0147
`define PCSR_CMD_RESET 16'h0000

// status bit positions
`define PCSR_STS_FASTB2B 7
`define PCSR_STS_DATAPAR 8
`define PCSR_STS_DEVSEL_LO 9
`define PCSR_STS_DEVSEL_HI 10
`define PCSR_STS_SIG_TABORT 11
`define PCSR_STS_RCV_TABORT 12
`define PCSR_STS_RCV_MABORT 13
`define PCSR_STS_SIG_SERR 14
`define PCSR_STS_PARITY 15

// fixed status fields and sticky reset value
`define PCSR_DEVSEL_MEDIUM 2'h1
`define PCSR_STS_FIXED 16'h0280
`define PCSR_STS_RESET 16'h0000

// space codes seen by the claim gate
`define PCSR_SPACE_IO 2'h0
`define PCSR_SPACE_MEM 2'h1
`define PCSR_SPACE_CFG 2'h2
`define PCSR_SPACE_SPECIAL 2'h3

`endif

// >>> design/pcsr_sticky_bit.v
`timescale 1ns/100ps
// one write-one-to-clear status flag, set wins over clear
module pcsr_sticky_bit
(
	// clock and reset
	input wire mclk,
	input wire rst,
	// event and clear
	input wire setEvt,
	input wire clrReq,
	// flag
	output wire flag
);

reg flag_reg;
wire flag_next;

assign flag_next = setEvt ? 1'b1 : (clrReq ? 1'b0 : flag_reg);
assign flag = flag_reg;

always @(posedge mclk or posedge rst)
begin
	if (rst)
		flag_reg <= 1'b0;
	else
		flag_reg <= flag_next;
end

endmodule // pcsr_sticky_bit

// >>> design/pcsr_access_gate.v
`timescale 1ns/100ps
`include "pcsr_map.vh"
// decides which bus cycles the device claims or may start
module pcsr_access_gate
(
	// enables from the command register
	input wire ioEn,
	input wire memEn,
	input wire masterEn,
	// target side decode
	input wire addrValid,
	input wire [1:0] addrSpace,
	input wire addrMatch,
	// master side request
	input wire masterReq,
	input wire masterBackToBack,
	input wire sameTarget,
	// decisions
	output reg targetClaim,
	output reg cfgClaim,
	output wire masterGo,
	output wire fastB2bGo
);

always @*
begin
	targetClaim = 1'b0;
	cfgClaim = 1'b0;
	if (addrValid)
	begin
		case (addrSpace)
			`PCSR_SPACE_IO: targetClaim = addrMatch & ioEn;
			`PCSR_SPACE_MEM: targetClaim = addrMatch & memEn;
			`PCSR_SPACE_CFG: cfgClaim = 1'b1;
			`PCSR_SPACE_SPECIAL: targetClaim = 1'b0;
			default: targetClaim = 1'b0;
		endcase
	end
end

assign masterGo = masterReq & masterEn;
assign fastB2bGo = masterGo & masterBackToBack & sameTarget;

endmodule // pcsr_access_gate

// >>> tb/pcsr_regs_sva.sv
`timescale 1ns/100ps
// enable gating and pin timing checks
module pcsr_regs_sva
(
	input wire mclk, rst, cfgRead, cfgRdValid, addrValid, addrMatch,
	input wire [7:0] cfgAddr,
	input wire [31:0] cfgRdData,
	input wire [1:0] addrSpace,
	input wire targetClaim, cfgClaim, masterReq, masterGo,
	input wire fastB2bGo, sameTarget, masterBackToBack,
	input wire dataParityErr, addrParityErr, systemErrReq,
	input wire perrOe, serrOe, ioSpaceEn, memSpaceEn,
	input wire busMasterEn, parityRespEn, serrEn,
	input wire cfgWrite, cfgHit, perrOut, serrOut
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence rdAns;
		##1 cfgRdValid;
	endsequence
	rd_answer_a: assert property (cfgRead |-> rdAns)
		else $error("read not answered");
	fixed_bits_a: assert property (cfgRdValid &&
		($past(cfgAddr) & 8'hFC) == 8'h04 |->
		(cfgRdData & 32'h0EFFFEB8) == 32'h02800000)
		else $error("fixed bits wrong");
	io_gate_a: assert property (targetClaim && addrSpace == 2'h0
		|-> ioSpaceEn) else $error("io claim while disabled");
	mem_gate_a: assert property (targetClaim && addrSpace == 2'h1
		|-> memSpaceEn) else $error("mem claim while disabled");
	special_a: assert property (addrValid && addrSpace == 2'h3
		|-> !targetClaim && !cfgClaim) else $error("special claimed");
	cfg_claim_a: assert property (addrValid && addrMatch &&
		addrSpace == 2'h2 |-> cfgClaim) else $error("config missed");
	master_gate_a: assert property (masterGo |-> masterReq &&
		busMasterEn) else $error("master without enable");
	fast_chain_a: assert property (fastB2bGo |-> masterGo &&
		sameTarget && masterBackToBack) else $error("bad chaining");
	perr_drive_a: assert property (perrOe ==
		($past(dataParityErr) && $past(parityRespEn)))
		else $error("parity pin wrong");
	serr_drive_a: assert property (serrOe == ($past(serrEn) &&
		($past(addrParityErr) && $past(parityRespEn) ||
		$past(systemErrReq)))) else $error("system error pin wrong");
	hit_decode_a: assert property (cfgHit == ((cfgRead || cfgWrite) &&
		(cfgAddr & 8'hFC) == 8'h04)) else $error("config hit wrong");
	pins_low_a: assert property (!perrOut && !serrOut)
		else $error("open drain level wrong");
endmodule // pcsr_regs_sva
bind pcsr_regs pcsr_regs_sva pcsr_regs_sva_i (.*);

// >>> tb/pcsr_host_model.sv
`timescale 1ns/100ps
// config host, callers enter just after a falling edge
module pcsr_host_model
(
	input wire mclk,
	input wire cfgRdValid,
	input wire [31:0] cfgRdData,
	output logic cfgRead = 1'b0,
	output logic cfgWrite = 1'b0,
	output logic [7:0] cfgAddr = 8'hFF,
	output logic [3:0] cfgByteEn = 4'h0,
	output logic [31:0] cfgWrData = 32'h0
);
	task wr(input [7:0] a, input [3:0] be, input [31:0] d);
	begin
		cfgWrite = 1'b1;
		cfgAddr = a;
		cfgByteEn = be;
		cfgWrData = d;
		@(negedge mclk);
		cfgWrite = 1'b0;
		cfgAddr = ~a;
		cfgWrData = ~d;
		@(negedge mclk);
	end
	endtask
	task rd(input [7:0] a, output [31:0] d);
	begin
		cfgRead = 1'b1;
		cfgAddr = a;
		@(negedge mclk);
		cfgRead = 1'b0;
		cfgAddr = ~a;
		d = cfgRdValid ? cfgRdData : 32'hBAD0BAD0;
		@(negedge mclk);
	end
	endtask
	// merge new command bits into what is there
	task cmd(input [15:0] m, input [15:0] v);
		logic [31:0] r;
	begin
		rd(8'h04, r);
		wr(8'h04, 4'h3, {16'h0, r[15:0] & ~m | v});
	end
	endtask
endmodule // pcsr_host_model

// >>> tb/test_pcsr_regs.sv
`timescale 1ns/100ps
module test_pcsr_regs;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] ev = 8'h00;
	logic [6:0] g = 7'h00;
	logic [31:0] r;
	int fail_count = 0;
	int checks_done = 0;
	int i;
	wire cfgRead, cfgWrite, cfgHit, cfgRdValid;
	wire targetClaim, cfgClaim, masterGo, fastB2bGo;
	wire [7:0] cfgAddr;
	wire [3:0] cfgByteEn;
	wire [31:0] cfgWrData, cfgRdData;
	wire [4:0] en;
	// command, events, expected status
	localparam logic [39:0] T [0:10] = '{40'h01470C0380,
		40'h0147181280, 40'h0147282280, 40'h0147680280, 40'h0147018280,
		40'h0147804280, 40'h014702C280, 40'h01070C0280, 40'h0107028280,
		40'h0047800280, 40'h0147100280};
	always #5 mclk = ~mclk;
	pcsr_host_model pcsr_host_model_i (.*);
	pcsr_regs pcsr_regs_i (.*, .addrValid(g[0]), .addrSpace(g[2:1]),
		.addrMatch(g[3]), .masterReq(g[4]), .masterBackToBack(g[5]),
		.sameTarget(g[6]), .dataParityErr(ev[0]), .addrParityErr(ev[1]),
		.perrSeen(ev[2]), .masterActive(ev[3]), .targetAbortRcvd(ev[4]),
		.masterAbortRcvd(ev[5]), .specialCycleXfer(ev[6]),
		.systemErrReq(ev[7]), .perrOut(), .perrOe(), .serrOut(),
		.serrOe(), .ioSpaceEn(en[0]), .memSpaceEn(en[1]),
		.busMasterEn(en[2]), .parityRespEn(en[3]), .serrEn(en[4]));
	task summarize;
	begin
		$display("checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
	begin
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	// every space code, claim and master decisions
	task gate(input e);
		int s;
	begin
		for (s = 0; s < 4; s++)
		begin
			g = {4'hF, s[1:0], 1'b1};
			#1;
			chk(targetClaim, e && s < 2);
			chk(cfgClaim, s == 2);
			chk({fastB2bGo, masterGo}, {e, e});
			@(negedge mclk);
		end
		g[6] = 1'b0;
		#1;
		chk(fastB2bGo, 1'b0);
		@(negedge mclk);
		g = 7'h00;
	end
	endtask
	initial
	begin
		#100000;
		fail_count++;
		summarize;
	end
	initial
	begin
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		pcsr_host_model_i.rd(8'h04, r);
		chk(r, 32'h02800000);
		gate(1'b0);
		pcsr_host_model_i.wr(8'h04, 4'hF, 32'h0000FFFF);
		pcsr_host_model_i.wr(8'h00, 4'hF, 32'h00000000);
		pcsr_host_model_i.rd(8'h04, r);
		chk(r, 32'h02800147);
		chk(en, 5'h1F);
		pcsr_host_model_i.rd(8'h08, r);
		chk(r, 32'h0);
		gate(1'b1);
		for (i = 0; i < 11; i++)
		begin
			pcsr_host_model_i.cmd(16'hFFFF, T[i][39:24]);
			ev = T[i][23:16];
			@(negedge mclk);
			ev = 8'h00;
			repeat (3) @(negedge mclk);
			pcsr_host_model_i.wr(8'h04, 4'hC, 32'h0);
			pcsr_host_model_i.rd(8'h04, r);
			chk(r[31:16], T[i][15:0]);
			pcsr_host_model_i.wr(8'h04, 4'hC, 32'hFFFF0000);
			pcsr_host_model_i.rd(8'h04, r);
			chk(r[31:16], 16'h0280);
		end
		ev = 8'h01;
		fork
			pcsr_host_model_i.wr(8'h04, 4'hC, 32'hFFFF0000);
			begin
				@(negedge mclk);
				ev = 8'h00;
			end
		join
		pcsr_host_model_i.rd(8'h04, r);
		chk(r[31:16], 16'h8280);
		summarize;
	end
endmodule // test_pcsr_regs
